// ### src/dcf_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the memory clock select block
// Assumes: 32-bit apb data, one register word per offset
// Notes:   the pending flag sits in a status word of our own, the synthesiser lock time is a constant here
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH

`define DCF_MODE_CFG_OFF    12'h094
`define DCF_STATUS_OFF      12'h098
`define DCF_FREQ_SEL_LSB    0
`define DCF_FREQ_SEL_MSB    2
`define DCF_FREQ_VALID_BIT  3
`define DCF_GEN_SEL_BIT     8
`define DCF_PENDING_BIT     0
`define DCF_RUNNING_BIT     1
`define DCF_BAD_CODE_BIT    2
`define DCF_MODE_CFG_RST    32'h0000_0000
`define DCF_CFG_WR_MASK     32'h0000_010f
`define DCF_LOCK_TIME_NS    1000
`define DCF_CLK_PERIOD_NS   5
`define DCF_LOCK_CYCLES     ((`DCF_LOCK_TIME_NS + `DCF_CLK_PERIOD_NS - 1) / `DCF_CLK_PERIOD_NS)

`endif

// ### src/dcf_freq_decode.sv
// Purpose: maps the generation select and the frequency code to a memory clock rate
// Assumes: purely combinational
// Notes:   reserved codes give none and raise bad_code_o
`timescale 1ns/1ps
module dcf_freq_decode (
  // selection
  input  wire logic               ddr3_i,
  input  wire logic [2:0]         code_i,
  // result
  output dcf_pkg::dcf_freq_t      freq_o,
  output logic                    bad_code_o
);
  import dcf_pkg::*;

  // table lookup per generation
  always_comb begin
    freq_o = DCF_MHZ_NONE;
    if (!ddr3_i) begin
      case (code_i)
        3'h0:    freq_o = DCF_MHZ_200;
        3'h1:    freq_o = DCF_MHZ_266;
        3'h2:    freq_o = DCF_MHZ_333;
        3'h3:    freq_o = DCF_MHZ_400;
        3'h4:    freq_o = DCF_MHZ_533;
        default: freq_o = DCF_MHZ_NONE;
      endcase
    end else begin
      case (code_i)
        3'h3:    freq_o = DCF_MHZ_400;
        3'h4:    freq_o = DCF_MHZ_533;
        3'h5:    freq_o = DCF_MHZ_667;
        3'h6:    freq_o = DCF_MHZ_800;
        default: freq_o = DCF_MHZ_NONE;
      endcase
    end
    bad_code_o = (freq_o == DCF_MHZ_NONE);
  end

endmodule // dcf_freq_decode

// ### src/dcf_pkg.sv
// Purpose: shared types of the memory clock select block
// Assumes: nothing beyond the header of constants
// Notes:   frequency codes and the apb carrier
package dcf_pkg;

  // memory clock frequencies that the synthesiser can produce
  typedef enum logic [3:0] {
    DCF_MHZ_NONE = 4'h0,
    DCF_MHZ_200  = 4'h1,
    DCF_MHZ_266  = 4'h2,
    DCF_MHZ_333  = 4'h3,
    DCF_MHZ_400  = 4'h4,
    DCF_MHZ_533  = 4'h5,
    DCF_MHZ_667  = 4'h6,
    DCF_MHZ_800  = 4'h7
  } dcf_freq_t;

  // apb request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcf_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dcf_apb_rsp_t;

  // memory clock output bundle
  typedef struct packed {
    logic      clk_en;
    dcf_freq_t freq;
    logic      ddr3;
  } dcf_mclk_t;

endpackage

// ### src/dcf_top.sv
// Purpose: configuration register and memory clock start control of one dram_channel_controller
// Assumes: apb slave, inputs synchronous to sys_clk_i, lock time given by LOCK_CYCLES
// Notes:   clk_en_i low freezes all state
// How it works
// - bit 8 picks ddr2 when 0, ddr3 when 1, per attached dimms
// - once valid is set with a non-reserved code the memory clock runs at the selected rate after LOCK_CYCLES of locking
// - ddr2 codes 0 to 4 give 200 to 533 mhz, 5 to 7 reserved
// - ddr3 codes 0 to 2 and 7 reserved, 3 to 6 give 400 to 800 mhz
// - bits 7:4 are reserved, read zero and do nothing
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_top #(
  parameter int unsigned LOCK_CYCLES = `DCF_LOCK_CYCLES
) (
  // clock and reset
  input  wire logic            sys_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            clk_en_i,
  // apb slave
  input  dcf_pkg::dcf_apb_req_t apb_req_i,
  output dcf_pkg::dcf_apb_rsp_t apb_rsp_o,
  // memory clock control
  output dcf_pkg::dcf_mclk_t    mclk_o,
  output logic                  freq_change_pending_o
);
  import dcf_pkg::*;

  typedef enum logic [2:0] {
    DCF_ST_IDLE = 3'b001,
    DCF_ST_LOCK = 3'b010,
    DCF_ST_RUN  = 3'b100
  } dcf_state_t;

  typedef struct packed {
    dcf_state_t  st;
    logic [31:0] cfg;
    logic [31:0] lock_cnt;
    logic [31:0] prdata;
    logic        pslverr;
    dcf_mclk_t   mclk;
  } dcf_regs_t;

  dcf_regs_t   r;
  dcf_regs_t   next_r;
  dcf_freq_t   dec_freq;
  logic        dec_bad;
  logic        acc;
  logic        wr;
  logic [31:0] status;

  // decode the currently programmed selection
  dcf_freq_decode u_dec (
    .ddr3_i     (r.cfg[`DCF_GEN_SEL_BIT]),
    .code_i     (r.cfg[`DCF_FREQ_SEL_MSB:`DCF_FREQ_SEL_LSB]),
    .freq_o     (dec_freq),
    .bad_code_o (dec_bad)
  );

  // apb access phase, zero wait states
  assign acc = apb_req_i.psel & apb_req_i.penable;
  assign wr  = acc & apb_req_i.pwrite;

  // status word seen by software
  always_comb begin
    status = 32'h0000_0000;
    status[`DCF_PENDING_BIT]  = (r.st == DCF_ST_LOCK);
    status[`DCF_RUNNING_BIT]  = r.mclk.clk_en;
    status[`DCF_BAD_CODE_BIT] = dec_bad;
  end

  // next state of all registers
  always_comb begin
    next_r = r;
    if (acc) begin
      next_r.pslverr = 1'b0;
      if (apb_req_i.paddr == `DCF_MODE_CFG_OFF) begin
        next_r.prdata = r.cfg;
        if (wr) begin
          next_r.cfg = apb_req_i.pwdata & `DCF_CFG_WR_MASK;
        end
      end else if (apb_req_i.paddr == `DCF_STATUS_OFF) begin
        next_r.prdata = status;
        next_r.pslverr = apb_req_i.pwrite;
      end else begin
        next_r.prdata = 32'h0000_0000;
        next_r.pslverr = 1'b1;
      end
    end
    // clock start sequencing
    case (r.st)
      DCF_ST_IDLE: begin
        next_r.mclk.clk_en = 1'b0;
        if (r.cfg[`DCF_FREQ_VALID_BIT] && !dec_bad) begin
          next_r.st = DCF_ST_LOCK;
          next_r.lock_cnt = 32'h0000_0000;
          next_r.mclk.freq = dec_freq;
          next_r.mclk.ddr3 = r.cfg[`DCF_GEN_SEL_BIT];
        end
      end
      DCF_ST_LOCK: begin
        if (!r.cfg[`DCF_FREQ_VALID_BIT]) begin
          next_r.st = DCF_ST_IDLE;
        end else if (r.lock_cnt >= LOCK_CYCLES - 1) begin
          next_r.st = DCF_ST_RUN;
          next_r.mclk.clk_en = 1'b1;
        end else begin
          next_r.lock_cnt = r.lock_cnt + 32'h0000_0001;
        end
      end
      DCF_ST_RUN: begin
        // a new or reserved selection or a cleared valid stops the clock, a valid new selection then relocks
        if (!r.cfg[`DCF_FREQ_VALID_BIT] || dec_bad || dec_freq != r.mclk.freq
            || r.cfg[`DCF_GEN_SEL_BIT] != r.mclk.ddr3) begin
          next_r.st = DCF_ST_IDLE;
          next_r.mclk.clk_en = 1'b0;
        end
      end
      default: begin
        next_r.st = DCF_ST_IDLE;
      end
    endcase
  end

  // state register with clock enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.st       <= DCF_ST_IDLE;
      r.cfg      <= `DCF_MODE_CFG_RST;
      r.lock_cnt <= 32'h0000_0000;
      r.prdata   <= 32'h0000_0000;
      r.pslverr  <= 1'b0;
      r.mclk     <= '0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // outputs
  assign apb_rsp_o.pready  = 1'b1;
  assign apb_rsp_o.pslverr = r.pslverr & 1'b0 | (acc & (apb_req_i.paddr != `DCF_MODE_CFG_OFF)
                             & ((apb_req_i.paddr != `DCF_STATUS_OFF) | apb_req_i.pwrite));
  assign apb_rsp_o.prdata  = (apb_req_i.paddr == `DCF_MODE_CFG_OFF) ? r.cfg
                           : (apb_req_i.paddr == `DCF_STATUS_OFF) ? status : 32'h0000_0000;
  assign mclk_o = r.mclk;
  assign freq_change_pending_o = (r.st == DCF_ST_LOCK);

endmodule // dcf_top

// ### tb/dcf_checker.sv
// Purpose: assertions on the ports of dcf_top
// Assumes: lock length given by LOCK_CYCLES
// Notes:   bound at the foot
`timescale 1ns/1ps
module dcf_checker import dcf_pkg::*; #(
  parameter int unsigned LOCK_CYCLES = 4
) (
  // clock and reset
  input wire logic    sys_clk_i,
  input wire logic    rst_n_i,
  input wire logic    clk_en_i,
  // watched ports
  input dcf_apb_req_t apb_req_i,
  input dcf_apb_rsp_t apb_rsp_o,
  input dcf_mclk_t    mclk_o,
  input wire logic    freq_change_pending_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic        acc;
  logic        start;
  logic [8:0]  wd;
  int unsigned pend_cnt;
  // access phase and a valid start request on a stopped clock
  assign acc = apb_req_i.psel && apb_req_i.penable;
  assign wd = apb_req_i.pwdata[8:0];
  assign start = acc && apb_req_i.pwrite && apb_req_i.paddr == 12'h094 && wd[3]
    && (wd[8] ? wd[2:0] inside {[3:6]} : wd[2:0] < 3'h5);
  // length of the current locking phase
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pend_cnt <= 0;
    else if (clk_en_i) pend_cnt <= freq_change_pending_o ? pend_cnt + 1 : 0;
  end
  sequence s_start;
    start && !mclk_o.clk_en && !freq_change_pending_o && clk_en_i;
  endsequence
  sequence s_cfg_rd;
    acc && !apb_req_i.pwrite && apb_req_i.paddr == 12'h094;
  endsequence
  a_ready_zero_wait: assert property (acc |-> apb_rsp_o.pready) else $error("pready low");
  a_rsvd_reads_zero: assert property (s_cfg_rd |-> apb_rsp_o.prdata[7:4] == 4'h0)
    else $error("reserved bits set");
  a_start_locks: assert property (s_start |-> ##[1:2] freq_change_pending_o) else $error("no lock");
  a_pend_no_clk: assert property (freq_change_pending_o |-> !mclk_o.clk_en) else $error("clk while pending");
  a_pend_bound: assert property (pend_cnt <= LOCK_CYCLES) else $error("lock too long");
  a_run_after_lock: assert property ($rose(mclk_o.clk_en) |->
    $past(freq_change_pending_o) || $past(freq_change_pending_o, 2)) else $error("clk without lock");
  a_ddr2_rates: assert property (mclk_o.clk_en && !mclk_o.ddr3 |-> mclk_o.freq inside {[DCF_MHZ_200:DCF_MHZ_533]})
    else $error("bad ddr2 rate");
  a_ddr3_rates: assert property (mclk_o.clk_en && mclk_o.ddr3 |-> mclk_o.freq inside {[DCF_MHZ_400:DCF_MHZ_800]})
    else $error("bad ddr3 rate");
endmodule // dcf_checker
bind dcf_top dcf_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .mclk_o(mclk_o),
  .freq_change_pending_o(freq_change_pending_o));

// ### tb/dcf_dimm_model.sv
// Purpose: dimm side of the memory clock
// Assumes: one dimm generation fitted
// Notes:   flags a running clock of the wrong generation
`timescale 1ns/1ps
module dcf_dimm_model import dcf_pkg::*; (
  input wire logic sys_clk_i,
  input dcf_mclk_t mclk_i,
  input wire logic ddr3_fit_i,
  output logic     gen_bad_o
);
  // a running clock must suit the fitted dimms
  always_ff @(posedge sys_clk_i) gen_bad_o <= mclk_i.clk_en && mclk_i.ddr3 != ddr3_fit_i;
endmodule // dcf_dimm_model

// ### tb/dcf_top_tb_top.sv
// Purpose: self-checking bench of dcf_top
// Assumes: lock shortened to LP cycles, clk_en_i held high
// Notes:   apb master and a model of the register and clock
`timescale 1ns/1ps
module dcf_top_tb_top;
  import dcf_pkg::*;
  localparam int LP = 4;
  logic         sys_clk_i = 0;
  logic         rst_n_i = 0;
  logic         ddr3_fit = 0;
  logic         bad, pend, err, rdy;
  logic [31:0]  rd;
  dcf_apb_req_t req = '0;
  dcf_apb_rsp_t rsp;
  dcf_mclk_t    mclk;
  int           n_mismatch = 0;
  int           checked = 0;
  int           n;
  always #2.5 sys_clk_i = ~sys_clk_i;
  dcf_top #(.LOCK_CYCLES(LP)) i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .apb_req_i(req), .apb_rsp_o(rsp), .mclk_o(mclk), .freq_change_pending_o(pend));
  dcf_dimm_model i_dimm (.sys_clk_i(sys_clk_i), .mclk_i(mclk), .ddr3_fit_i(ddr3_fit), .gen_bad_o(bad));
  // verdict and end of run
  task test_done;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, answer taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk_i) req.penable <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      rd = rsp.prdata;
      err = rsp.pslverr;
      rdy = rsp.pready;
    end while (rdy !== 1'b1);
    req <= '0;
  endtask
  // model: rate code of a generation and code, zero when reserved
  function automatic int rate(input int g, input int c);
    return ((g == 0 && c <= 4) || (g == 1 && c >= 3 && c <= 6)) ? c + 1 : 0;
  endfunction
  // watchdog
  initial begin
    #(20000 * 5);
    n_mismatch++;
    test_done;
  end
  // main sequence
  initial begin
    int w, f;
    n = $urandom(32'h1d1957ab);
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    apb(0, 12'h094, 0);
    chk(rd, 32'h0);
    apb(0, 12'h0f0, 0);
    chk({31'h0, err}, 32'h1);
    for (int g = 0; g < 2; g++) begin
      ddr3_fit <= g[0];
      for (int c = 0; c < 8; c++) begin
        f = rate(g, c);
        w = (g << 8) | c | ($urandom & 32'hf0);
        apb(1, 12'h094, w);
        apb(1, 12'h094, w | 8);
        n = 0;
        repeat (LP + 4) @(negedge sys_clk_i) n += pend;
        chk(n, f ? LP : 0);
        chk({31'h0, mclk.clk_en}, {31'h0, f != 0});
        if (f != 0) chk({mclk.freq, mclk.ddr3}, {f[3:0], g[0]});
        apb(0, 12'h094, 0);
        chk(rd, (w | 8) & 32'h10f);
        apb(0, 12'h098, 0);
        chk(rd, f ? 32'h2 : 32'h4);
        chk({31'h0, bad}, 32'h0);
        apb(1, 12'h094, w);
        apb(1, 12'h098, 0);
        chk({31'h0, err, mclk.clk_en}, 32'h2);
      end
    end
    test_done;
  end
endmodule // dcf_top_tb_top
